// >>> logic/tadp_pkg.sv
`default_nettype none

package tadp_pkg;

    // instruction register layout and codes
    localparam int unsigned IR_W       = 4;
    localparam logic [3:0]  IR_CAPTURE = 4'h1;
    localparam logic [3:0]  IR_IDCODE  = 4'h2;
    localparam logic [3:0]  IR_DEBUG   = 4'h8;
    localparam logic [3:0]  IR_BYPASS  = 4'hF;

    // data register width and reset value
    localparam int unsigned DR_W     = 32;
    localparam logic [31:0] DR_RESET = 32'h0000_0000;

    // sixteen test controller states, one-hot
    typedef enum logic [15:0] {
        S_TLR    = 16'h0001,
        S_RTI    = 16'h0002,
        S_SEL_DR = 16'h0004,
        S_CAP_DR = 16'h0008,
        S_SHF_DR = 16'h0010,
        S_EX1_DR = 16'h0020,
        S_PAU_DR = 16'h0040,
        S_EX2_DR = 16'h0080,
        S_UPD_DR = 16'h0100,
        S_SEL_IR = 16'h0200,
        S_CAP_IR = 16'h0400,
        S_SHF_IR = 16'h0800,
        S_EX1_IR = 16'h1000,
        S_PAU_IR = 16'h2000,
        S_EX2_IR = 16'h4000,
        S_UPD_IR = 16'h8000
    } tadp_state_e;

    // serial inputs sampled on the test clock
    typedef struct packed {
        logic tms;
        logic tdi;
    } tadp_tap_in_s;

    // drive of the shared pad
    typedef struct packed {
        logic o;
        logic oe;
    } tadp_pad_s;

endpackage

`default_nettype wire

// >>> logic/tadp_core.sv
`default_nettype none

module tadp_core
    import tadp_pkg::*;
#(
    parameter logic [31:0] DEV_ID     = 32'h0000_1001, // arbitrary value
    parameter logic [31:0] FACTORY_ID = 32'h0000_2001  // arbitrary value
)(
    // system clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // test port pins
    input  wire logic            tck,
    input  wire logic            trst_n,
    input  wire tadp_tap_in_s    tap_in,
    input  wire logic            test_controller_select_alt,
    output logic                 tdo,
    output logic                 tdo_oe,
    // shared pad: returned clock or single-wire link
    input  wire logic            pad_i,
    output tadp_pad_s            pad_out,
    input  wire logic            single_wire_en,
    input  wire logic            single_wire_tx,
    output logic                 single_wire_rx,
    // system side view
    output logic                 factory_mode,
    output logic [DR_W-1:0]      dbg_word,
    output logic                 dbg_word_valid
);

    // test clock domain state
    logic                sel_d;
    logic                sel_q;
    tadp_state_e         state_d;
    tadp_state_e         state_q;
    logic [IR_W-1:0]     ir_d;
    logic [IR_W-1:0]     ir_q;
    logic [IR_W-1:0]     ir_sh_d;
    logic [IR_W-1:0]     ir_sh_q;
    logic [DR_W-1:0]     dr_d;
    logic [DR_W-1:0]     dr_q;
    logic                byp_d;
    logic                byp_q;
    logic [DR_W-1:0]     hold_d;
    logic [DR_W-1:0]     hold_q;
    logic                tog_d;
    logic                tog_q;
    logic                live_d;
    logic                live_q;
    logic                tdo_d;
    logic                tdo_q;
    logic                tdo_oe_d;
    logic                tdo_oe_q;
    logic                factory;
    logic [IR_W-1:0]     ir_eff;
    logic                dr_used;
    logic [DR_W-1:0]     id_val;

    // system clock domain state
    logic                tck_s1_q;
    logic                tck_s2_q;
    logic                tog_s1_q;
    logic                tog_s2_q;
    logic                tog_seen_q;
    logic                sel_s1_q;
    logic                sel_s2_q;
    logic                pad_s1_q;
    logic                pad_s2_q;
    tadp_pad_s           pad_d;
    tadp_pad_s           pad_q;
    logic [DR_W-1:0]     word_d;
    logic [DR_W-1:0]     word_q;
    logic                valid_d;
    logic                valid_q;

    // strap caught on the rising edge of test reset
    always_comb
    begin
        sel_d = test_controller_select_alt;
    end

    always_ff @(posedge trst_n)
    begin
        sel_q <= sel_d;
    end

    // low strap routes to the factory controller
    always_comb
    begin
        factory = !sel_q;
        id_val  = factory ? FACTORY_ID : DEV_ID;
        // factory controller offers only id and bypass
        if (ir_q == IR_IDCODE || (ir_q == IR_DEBUG && !factory))
            ir_eff = ir_q;
        else
            ir_eff = IR_BYPASS;
        dr_used = (ir_eff != IR_BYPASS);
    end

    // controller next state and register actions
    always_comb
    begin
        state_d = state_q;
        ir_d    = ir_q;
        ir_sh_d = ir_sh_q;
        dr_d    = dr_q;
        byp_d   = byp_q;
        hold_d  = hold_q;
        tog_d   = tog_q;
        live_d  = 1'b1; // set by the first edge after test reset
        unique case (state_q)
            S_TLR:    state_d = tap_in.tms ? S_TLR    : S_RTI;
            S_RTI:    state_d = tap_in.tms ? S_SEL_DR : S_RTI;
            S_SEL_DR: state_d = tap_in.tms ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: state_d = tap_in.tms ? S_EX1_DR : S_SHF_DR;
            S_SHF_DR: state_d = tap_in.tms ? S_EX1_DR : S_SHF_DR;
            S_EX1_DR: state_d = tap_in.tms ? S_UPD_DR : S_PAU_DR;
            S_PAU_DR: state_d = tap_in.tms ? S_EX2_DR : S_PAU_DR;
            S_EX2_DR: state_d = tap_in.tms ? S_UPD_DR : S_SHF_DR;
            S_UPD_DR: state_d = tap_in.tms ? S_SEL_DR : S_RTI;
            S_SEL_IR: state_d = tap_in.tms ? S_TLR    : S_CAP_IR;
            S_CAP_IR: state_d = tap_in.tms ? S_EX1_IR : S_SHF_IR;
            S_SHF_IR: state_d = tap_in.tms ? S_EX1_IR : S_SHF_IR;
            S_EX1_IR: state_d = tap_in.tms ? S_UPD_IR : S_PAU_IR;
            S_PAU_IR: state_d = tap_in.tms ? S_EX2_IR : S_PAU_IR;
            S_EX2_IR: state_d = tap_in.tms ? S_UPD_IR : S_SHF_IR;
            S_UPD_IR: state_d = tap_in.tms ? S_SEL_DR : S_RTI;
            default:  state_d = S_TLR;
        endcase
        unique case (state_q)
            S_TLR:    ir_d    = IR_IDCODE;
            S_CAP_IR: ir_sh_d = IR_CAPTURE;
            S_SHF_IR: ir_sh_d = {tap_in.tdi, ir_sh_q[IR_W-1:1]};
            S_UPD_IR: ir_d    = ir_sh_q;
            S_CAP_DR:
            begin
                byp_d = 1'b0;
                dr_d  = (ir_eff == IR_IDCODE) ? id_val : hold_q;
            end
            S_SHF_DR:
            begin
                byp_d = tap_in.tdi;
                dr_d  = {tap_in.tdi, dr_q[DR_W-1:1]};
            end
            S_UPD_DR:
            begin
                if (ir_eff == IR_DEBUG)
                begin
                    hold_d = dr_q;
                    tog_d  = !tog_q;
                end
            end
            default: ;
        endcase
    end

    // rising test clock, asynchronous test reset
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
        begin
            state_q <= S_TLR;
            ir_q    <= IR_IDCODE;
            ir_sh_q <= IR_CAPTURE;
            dr_q    <= DR_RESET;
            byp_q   <= 1'b0;
            hold_q  <= DR_RESET;
            tog_q   <= 1'b0;
            live_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ir_q    <= ir_d;
            ir_sh_q <= ir_sh_d;
            dr_q    <= dr_d;
            byp_q   <= byp_d;
            hold_q  <= hold_d;
            tog_q   <= tog_d;
            live_q  <= live_d;
        end
    end

    // serial output value for the next falling edge
    always_comb
    begin
        tdo_d    = 1'b0;
        tdo_oe_d = 1'b0;
        if (state_q == S_SHF_IR)
        begin
            tdo_d    = ir_sh_q[0];
            tdo_oe_d = 1'b1;
        end
        else if (state_q == S_SHF_DR)
        begin
            tdo_d    = dr_used ? dr_q[0] : byp_q;
            tdo_oe_d = 1'b1;
        end
    end

    // falling test clock updates the serial output
    always_ff @(negedge tck or negedge trst_n)
    begin
        if (!trst_n)
        begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else
        begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign tdo    = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // pad drive: returned clock unless single-wire owns it
    always_comb
    begin
        if (single_wire_en)
        begin
            pad_d.o  = 1'b0;
            pad_d.oe = !single_wire_tx;
        end
        else
        begin
            pad_d.o  = tck_s2_q;
            pad_d.oe = 1'b1;
        end
        valid_d = tog_s2_q ^ tog_seen_q;
        word_d  = valid_d ? hold_q : word_q;
    end

    // system clock: synchronisers, pad, debug word
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tck_s1_q   <= 1'b0;
            tck_s2_q   <= 1'b0;
            tog_s1_q   <= 1'b0;
            tog_s2_q   <= 1'b0;
            tog_seen_q <= 1'b0;
            sel_s1_q   <= 1'b0;
            sel_s2_q   <= 1'b0;
            pad_s1_q   <= 1'b1;
            pad_s2_q   <= 1'b1;
            pad_q      <= '0;
            word_q     <= DR_RESET;
            valid_q    <= 1'b0;
        end
        else
        begin
            tck_s1_q   <= tck;
            tck_s2_q   <= tck_s1_q;
            tog_s1_q   <= tog_q;
            tog_s2_q   <= tog_s1_q;
            tog_seen_q <= tog_s2_q;
            sel_s1_q   <= factory;
            sel_s2_q   <= sel_s1_q;
            pad_s1_q   <= pad_i;
            pad_s2_q   <= pad_s1_q;
            pad_q      <= pad_d;
            word_q     <= word_d;
            valid_q    <= valid_d;
        end
    end

    assign pad_out        = pad_q;
    assign single_wire_rx = pad_s2_q;
    assign factory_mode   = sel_s2_q;
    assign dbg_word       = word_q;
    assign dbg_word_valid = valid_q;

    // checks in the test clock domain, except AST_TRST_INIT on the system clock
    AST_SEL_HELD: assert property (@(posedge tck) disable iff (!trst_n)
        live_q |-> $stable(sel_q))
        else $error("controller select changed while test reset high");

    AST_FACTORY_ID: assert property (@(posedge tck) disable iff (!trst_n)
        (state_q == S_CAP_DR && ir_eff == IR_IDCODE)
        |=> dr_q == (sel_q ? DEV_ID : FACTORY_ID))
        else $error("captured id does not match selected controller");

    AST_TRST_INIT: assert property (@(posedge clk) disable iff (sys_rst)
        !trst_n |-> (state_q == S_TLR && !tdo_oe))
        else $error("controller not initialised under test reset");

    AST_TDO_FALL: assert property (@(posedge tck) disable iff (!trst_n)
        (state_q == S_SHF_DR && dr_used) |-> (tdo_oe && tdo == dr_q[0]))
        else $error("serial output not set up by falling edge");

    AST_TDI_RISE: assert property (@(posedge tck) disable iff (!trst_n)
        state_q == S_SHF_DR |=> byp_q == $past(tap_in.tdi))
        else $error("serial input not sampled on rising edge");

    AST_TMS_STEP: assert property (@(posedge tck) disable iff (!trst_n)
        (state_q == S_RTI && tap_in.tms) |=> state_q == S_SEL_DR)
        else $error("mode select did not step controller");

    AST_FIVE_ONES: assert property (@(posedge tck) disable iff (!trst_n)
        tap_in.tms [*5] |=> state_q == S_TLR)
        else $error("five high mode selects did not reach reset state");

    // checks in the system clock domain
    AST_RETURNED_TEST_CLOCK_FOLLOW: assert property (@(posedge clk) disable iff (sys_rst)
        (!single_wire_en && $changed(tck_s2_q)) |=> pad_out.o == $past(tck_s2_q))
        else $error("returned clock did not follow test clock");

    AST_RETURNED_TEST_CLOCK_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
        (!sys_rst && !single_wire_en) |=> pad_out.oe)
        else $error("returned clock not driven");

    AST_PAD_SHARE: assert property (@(posedge clk) disable iff (sys_rst)
        (single_wire_en && single_wire_tx) |=> (!pad_out.oe && !pad_out.o))
        else $error("returned clock drove pad owned by single-wire");

endmodule // tadp_core

`default_nettype wire

// >>> logic/tadp_core_unused_guard.sv
`default_nettype none
`default_nettype wire

// >>> bench/tadp_dbg_model.sv
`default_nettype none
module tadp_dbg_model
    import tadp_pkg::*;
(
    // pins toward the test port
    output logic         tck,
    output logic         trst_n,
    output tadp_tap_in_s tap_in,
    output logic         sel
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle levels, test clock stands still low between steps
    initial
    begin
        tck = 1'b0;
        trst_n = 1'b1; // released idle, first pulse gives a clean fall
        tap_in = '0;
        sel = 1'b1;
    end
    // pulse test reset with clock stopped, strap flipped after release
    task automatic treset(input logic s);
        trst_n = 1'b0;
        sel = s;
        #200 trst_n = 1'b1;
        #10 sel = ~s;
        #200;
    endtask
    // one clock period: inputs move after the fall, device samples on the rise
    task automatic step(input logic ms, input logic di);
        #1 tap_in = '{tms: ms, tdi: di};
        #61.5 tck = 1'b1;
        #62.5 tck = 1'b0;
    endtask
endmodule // tadp_dbg_model
`default_nettype wire

// >>> bench/test_test_access_debug_port.sv
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_test_access_debug_port
    import tadp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] ID_N = 32'h0000_1001; // arbitrary value
    localparam logic [31:0] ID_F = 32'h0000_2001; // arbitrary value
    logic            clk, sys_rst, ext_n, sw_en, sw_tx, pad_i;
    logic            tck, trst_n, sel, tdo, tdo_oe, sw_rx, fmode, wvalid;
    tadp_tap_in_s    tap_in;
    tadp_pad_s       pad_out;
    logic [DR_W-1:0] word, w1, w2;
    logic [1:0]      cur;
    int              bad_count, total_checks;
    logic [1:0]      exp_bit[$];
    logic [DR_W-1:0] exp_word[$];
    // wire level: pull-up unless a party pulls low
    assign pad_i = (pad_out.oe ? pad_out.o : 1'b1) & ext_n;
    tadp_dbg_model m (.tck(tck), .trst_n(trst_n), .tap_in(tap_in), .sel(sel));
    tadp_core #(.DEV_ID(ID_N), .FACTORY_ID(ID_F)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .tck(tck), .trst_n(trst_n), .tap_in(tap_in),
        .test_controller_select_alt(sel), .tdo(tdo), .tdo_oe(tdo_oe), .pad_i(pad_i),
        .pad_out(pad_out), .single_wire_en(sw_en), .single_wire_tx(sw_tx),
        .single_wire_rx(sw_rx), .factory_mode(fmode), .dbg_word(word),
        .dbg_word_valid(wvalid));
    always #5 clk = ~clk;
    // serial output as the debugger samples it
    always @(posedge tck)
        if (tdo_oe === 1'b1)
        begin
            `CHK(exp_bit.size() != 0, 1'b1)
            cur = exp_bit.pop_front();
            if (cur[1]) `CHK(tdo, cur[0])
        end
    // written words seen on the system side
    always @(posedge clk)
        if (wvalid === 1'b1)
            `CHK(word, exp_word.pop_front())
    // returned clock high before the fall
    always @(negedge tck)
        if (sw_en === 1'b0 && sys_rst === 1'b0)
            `CHK(pad_out, 2'b11)
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic walk(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++)
            m.step(seq[i], 1'b0);
    endtask
    // shift n bits, note expected output, then update and idle
    task automatic shift(input logic [31:0] din, input int n, input logic [31:0] dout,
                         input logic care);
        for (int i = 0; i < n; i++)
        begin
            exp_bit.push_back({care, dout[i]});
            m.step(i == n - 1, din[i]);
        end
        walk(8'h01, 2);
    endtask
    task automatic ir(input logic [3:0] code);
        walk(8'h03, 4);
        shift({28'h0, code}, IR_W, {28'h0, IR_CAPTURE}, 1'b1);
    endtask
    task automatic dr(input logic [31:0] din, input logic [31:0] dout, input logic care,
                      input int n);
        walk(8'h01, 3);
        shift(din, n, dout, care);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    initial
    begin
        #200000;
        bad_count++;
        stop_test();
    end
    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        ext_n = 1'b1;
        sw_en = 1'b0;
        sw_tx = 1'b1;
        void'($urandom(46));
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        m.treset(1'b1);
        `CHK(fmode, 1'b0)
        walk(8'h1F, 6);
        dr($urandom, ID_N, 1'b1, 32);
        done("id");
        w1 = $urandom;
        w2 = $urandom;
        ir(IR_DEBUG);
        exp_word.push_back(w1);
        dr(w1, DR_RESET, 1'b1, 32);
        exp_word.push_back(w2);
        dr(w2, w1, 1'b1, 32);
        ir(IR_BYPASS);
        dr(w1, w1 << 1, 1'b1, 8);
        done("debug");
        walk(8'h01, 3);
        fork
            m.treset(1'b1);
            #100 `CHK(tdo_oe, 1'b0)
        join
        walk(8'h00, 1);
        dr(w2, ID_N, 1'b1, 32);
        done("async");
        m.treset(1'b0);
        `CHK(fmode, 1'b1)
        walk(8'h1F, 6);
        dr(w1, ID_F, 1'b1, 32);
        ir(IR_DEBUG);
        dr(w2, w2 << 1, 1'b1, 8);
        m.treset(1'b1);
        `CHK(fmode, 1'b0)
        done("factory");
        @(posedge clk);
        sw_en <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            sw_tx <= 1'($urandom);
            ext_n <= 1'($urandom);
            repeat (4) @(posedge clk);
            #1;
            `CHK(pad_out, {1'b0, ~sw_tx})
            `CHK(sw_rx, sw_tx & ext_n)
        end
        sw_en <= 1'b0;
        ext_n <= 1'b1;
        repeat (4) @(posedge clk);
        walk(8'h1F, 6);
        done("pad");
        `CHK(exp_bit.size(), 0)
        `CHK(exp_word.size(), 0)
        stop_test();
    end
endmodule // test_test_access_debug_port
`default_nettype wire
